// file: logic/scl_map.vh
`ifndef SCL_MAP_VH
`define SCL_MAP_VH

// field positions in the assembled strap word
`define SCL_BIT_FREQ_LO      0
`define SCL_BIT_FREQ_HI      1
`define SCL_BIT_QDEPTH       2
`define SCL_BIT_PORT_SEL     3
`define SCL_WORD_W           4

// reset values
`define SCL_RST_WORD         4'h0
`define SCL_RST_NEXT_PTR     8'h00

// frequency select encodings
`define SCL_FREQ_100_400     2'h0
`define SCL_FREQ_133_533     2'h1
`define SCL_FREQ_200_800     2'h2
`define SCL_FREQ_RSVD        2'h3

// in-order queue depths
`define SCL_QDEPTH_MIN       4'h1
`define SCL_QDEPTH_MAX       4'hc

// port select values
`define SCL_SEL_VIDEO        1'h0
`define SCL_SEL_GPORT        1'h1

`endif

// file: logic/scl_strap_latch.v
// What this block does
// - strap low gives video mode, high port mode
// - version-three detect forces port select to one
// - select zero disables port, configs go hub
// - video mode: next-pointer reads zero, ignores writes
// - queue-depth bit mirrors strap, depth 1/12
// - frequency field latched at power-good rise, read-only
// - encodings 00/01/10 defined, 11 reserved
`timescale 1ns/1ps
`default_nettype none
`include "scl_map.vh"

module scl_strap_latch (
  input  wire       clk,
  input  wire       rst,
  input  wire       power_good,
  input  wire       add_detect_strap,
  input  wire       queue_depth_strap_pin,
  input  wire [1:0] bus_select_straps,
  input  wire       port_v3_detect_bit,
  input  wire       cfg_to_port,
  input  wire       cap_wr,
  input  wire [7:0] cap_wdata,
  output reg  [3:0] strap_word,
  output reg        graphics_port_select,
  output reg        digital_video_out_mode,
  output reg        graphics_port_enable,
  output reg        cfg_claim_port,
  output reg        cfg_pass_hub_link,
  output reg  [7:0] cap_next_ptr,
  output reg        inorder_queue_depth_bit,
  output reg  [3:0] inorder_queue_depth,
  output reg  [1:0] bus_frequency_select,
  output reg        freq_reserved
);

  ////////////////////////////////////////////////////////////////////////
  // synchronised pins
  wire [4:0] pins_s;

  scl_sync3 #(
    .W (5)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({power_good, add_detect_strap, queue_depth_strap_pin, bus_select_straps}),
    .q   (pins_s)
  );

  wire       pg_s     = pins_s[4];
  wire       detect_s = pins_s[3];
  wire       qd_s     = pins_s[2];
  wire [1:0] bsel_s   = pins_s[1:0];

  ////////////////////////////////////////////////////////////////////////
  // power-good edge tracker
  localparam [1:0] PG_LOW  = 2'h1;
  localparam [1:0] PG_HIGH = 2'h2;

  reg [1:0] pg_state_r;
  reg [1:0] pg_state_nxt;
  reg       pg_rise;

  always @* begin
    pg_state_nxt = pg_state_r;
    pg_rise      = 1'h0;
    case (pg_state_r)
      PG_LOW: begin
        if (pg_s) begin
          pg_state_nxt = PG_HIGH;
          pg_rise      = 1'h1;
        end
      end
      PG_HIGH: begin
        if (!pg_s) begin
          pg_state_nxt = PG_LOW;
        end
      end
      default: begin
        pg_state_nxt = PG_LOW;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      pg_state_r <= PG_LOW;
    end else begin
      pg_state_r <= pg_state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strap capture, one latch per strap bit
  localparam [`SCL_WORD_W-1:0] LAT_RST = `SCL_RST_WORD;

  wire [`SCL_WORD_W-1:0] strap_s = {detect_s, qd_s, bsel_s};
  reg  [`SCL_WORD_W-1:0] strap_lat_r;

  genvar b;
  generate
    for (b = 0; b < `SCL_WORD_W; b = b + 1) begin : g_lat
      always @(posedge clk) begin
        if (rst) begin
          strap_lat_r[b] <= LAT_RST[b];
        end else if (pg_rise) begin
          strap_lat_r[b] <= strap_s[b];
        end
      end
    end
  endgenerate

  wire       detect_lat = strap_lat_r[`SCL_BIT_PORT_SEL];
  wire       qd_lat     = strap_lat_r[`SCL_BIT_QDEPTH];
  wire [1:0] freq_lat   = strap_lat_r[`SCL_BIT_FREQ_HI:`SCL_BIT_FREQ_LO];

  ////////////////////////////////////////////////////////////////////////
  // effective port select, detect bit overrides strap
  wire sel_nxt = port_v3_detect_bit ? `SCL_SEL_GPORT : detect_lat;

  ////////////////////////////////////////////////////////////////////////
  // stored capability pointer, writes dropped in video mode
  reg [7:0] cap_ptr_r;

  always @(posedge clk) begin
    if (rst) begin
      cap_ptr_r <= `SCL_RST_NEXT_PTR;
    end else if (cap_wr && sel_nxt) begin
      cap_ptr_r <= cap_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port mode outputs
  always @(posedge clk) begin
    if (rst) begin
      strap_word             <= `SCL_RST_WORD;
      graphics_port_select   <= `SCL_SEL_VIDEO;
      digital_video_out_mode <= 1'h0;
      graphics_port_enable   <= 1'h0;
    end else begin
      strap_word             <= {sel_nxt, qd_lat, freq_lat};
      graphics_port_select   <= sel_nxt;
      digital_video_out_mode <= ~sel_nxt;
      graphics_port_enable   <= sel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration cycle routing
  always @(posedge clk) begin
    if (rst) begin
      cfg_claim_port    <= 1'h0;
      cfg_pass_hub_link <= 1'h0;
    end else begin
      cfg_claim_port    <= cfg_to_port & sel_nxt;
      cfg_pass_hub_link <= cfg_to_port & ~sel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capability next pointer, zero in video mode
  always @(posedge clk) begin
    if (rst) begin
      cap_next_ptr <= `SCL_RST_NEXT_PTR;
    end else if (sel_nxt) begin
      cap_next_ptr <= cap_ptr_r;
    end else begin
      cap_next_ptr <= `SCL_RST_NEXT_PTR;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // in-order queue depth
  always @(posedge clk) begin
    if (rst) begin
      inorder_queue_depth_bit <= 1'h0;
      inorder_queue_depth     <= `SCL_QDEPTH_MIN;
    end else if (qd_lat) begin
      inorder_queue_depth_bit <= 1'h1;
      inorder_queue_depth     <= `SCL_QDEPTH_MAX;
    end else begin
      inorder_queue_depth_bit <= 1'h0;
      inorder_queue_depth     <= `SCL_QDEPTH_MIN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frequency select and reserved code decode
  reg freq_rsvd_nxt;

  always @* begin
    freq_rsvd_nxt = 1'h0;
    case (freq_lat)
      `SCL_FREQ_100_400: begin
        freq_rsvd_nxt = 1'h0;
      end
      `SCL_FREQ_133_533: begin
        freq_rsvd_nxt = 1'h0;
      end
      `SCL_FREQ_200_800: begin
        freq_rsvd_nxt = 1'h0;
      end
      `SCL_FREQ_RSVD: begin
        freq_rsvd_nxt = 1'h1;
      end
      default: begin
        freq_rsvd_nxt = 1'h0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      bus_frequency_select <= `SCL_FREQ_100_400;
      freq_reserved        <= 1'h0;
    end else begin
      bus_frequency_select <= freq_lat;
      freq_reserved        <= freq_rsvd_nxt;
    end
  end

endmodule

`default_nettype wire

// file: logic/scl_sync3.v
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; change accepted when stages two and three agree
module scl_sync3 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (rst) begin
          s1_r[i] <= 1'h0;
          s2_r[i] <= 1'h0;
          s3_r[i] <= 1'h0;
          q[i]    <= 1'h0;
        end else begin
          s1_r[i] <= d[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            q[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// file: test/scl_board.sv
`timescale 1ns/1ps
`default_nettype none
// strap resistors and power-good source
module scl_board (
  input wire logic       clk,
  input wire logic [4:0] req,
  output logic     [4:0] p = 5'h00
);
  always @(posedge clk) p <= req;
endmodule
`default_nettype wire

// file: test/scl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module scl_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       power_good,
  input wire logic       port_v3_detect_bit,
  input wire logic       cfg_to_port,
  input wire logic       graphics_port_select,
  input wire logic       digital_video_out_mode,
  input wire logic       graphics_port_enable,
  input wire logic       cfg_claim_port,
  input wire logic       cfg_pass_hub_link,
  input wire logic       inorder_queue_depth_bit,
  input wire logic       freq_reserved,
  input wire logic [7:0] cap_next_ptr,
  input wire logic [3:0] inorder_queue_depth,
  input wire logic [1:0] bus_frequency_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_vid2; cfg_to_port && !graphics_port_select ##1 !graphics_port_select; endsequence
  property p_dvo; !rst |=> (digital_video_out_mode != graphics_port_select); endproperty
  a_dvo: assert property (p_dvo) else $error("both modes set");
  property p_v3; port_v3_detect_bit |=> graphics_port_select; endproperty
  a_v3: assert property (p_v3) else $error("detect did not force select");
  property p_hub; s_vid2 |-> cfg_pass_hub_link && !cfg_claim_port; endproperty
  a_hub: assert property (p_hub) else $error("config not passed on");
  property p_en; graphics_port_enable == graphics_port_select; endproperty
  a_en: assert property (p_en) else $error("enable differs from select");
  property p_ptr; digital_video_out_mode [*2] |-> cap_next_ptr == 8'h00; endproperty
  a_ptr: assert property (p_ptr) else $error("pointer nonzero in video mode");
  property p_qd; inorder_queue_depth == (inorder_queue_depth_bit ? 4'hc : 4'h1); endproperty
  a_qd: assert property (p_qd) else $error("queue depth wrong");
  property p_frq; $changed(bus_frequency_select) |-> $past(power_good) && !$past(power_good, 8); endproperty
  a_frq: assert property (p_frq) else $error("freq changed off capture");
  property p_rsv; freq_reserved == (bus_frequency_select == 2'h3); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
endmodule
bind scl_strap_latch scl_checker chk_i (
  .clk                     (clk),
  .rst                     (rst),
  .power_good              (power_good),
  .port_v3_detect_bit      (port_v3_detect_bit),
  .cfg_to_port             (cfg_to_port),
  .graphics_port_select    (graphics_port_select),
  .digital_video_out_mode  (digital_video_out_mode),
  .graphics_port_enable    (graphics_port_enable),
  .cfg_claim_port          (cfg_claim_port),
  .cfg_pass_hub_link       (cfg_pass_hub_link),
  .inorder_queue_depth_bit (inorder_queue_depth_bit),
  .freq_reserved           (freq_reserved),
  .cap_next_ptr            (cap_next_ptr),
  .inorder_queue_depth     (inorder_queue_depth),
  .bus_frequency_select    (bus_frequency_select)
);
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rst = 1, pg_q = 0, port_v3_detect_bit = 0, cfg_to_port = 0, cap_wr = 0;
  logic [3:0] st_q = 4'h0, strap_word, inorder_queue_depth;
  logic [7:0] cap_wdata = 8'h00, cap_next_ptr;
  logic [1:0] bus_frequency_select;
  logic graphics_port_select, digital_video_out_mode, graphics_port_enable, cfg_claim_port;
  logic cfg_pass_hub_link, inorder_queue_depth_bit, freq_reserved;
  wire logic power_good, add_detect_strap, queue_depth_strap_pin;
  wire logic [1:0] bus_select_straps;
  int n_fail = 0, check_count = 0;
  always #5 clk = ~clk;
  scl_strap_latch uut (
    .clk                     (clk),
    .rst                     (rst),
    .power_good              (power_good),
    .add_detect_strap        (add_detect_strap),
    .queue_depth_strap_pin   (queue_depth_strap_pin),
    .bus_select_straps       (bus_select_straps),
    .port_v3_detect_bit      (port_v3_detect_bit),
    .cfg_to_port             (cfg_to_port),
    .cap_wr                  (cap_wr),
    .cap_wdata               (cap_wdata),
    .strap_word              (strap_word),
    .graphics_port_select    (graphics_port_select),
    .digital_video_out_mode  (digital_video_out_mode),
    .graphics_port_enable    (graphics_port_enable),
    .cfg_claim_port          (cfg_claim_port),
    .cfg_pass_hub_link       (cfg_pass_hub_link),
    .cap_next_ptr            (cap_next_ptr),
    .inorder_queue_depth_bit (inorder_queue_depth_bit),
    .inorder_queue_depth     (inorder_queue_depth),
    .bus_frequency_select    (bus_frequency_select),
    .freq_reserved           (freq_reserved)
  );
  scl_board brd (.clk(clk), .req({pg_q, st_q}),
    .p({power_good, add_detect_strap, queue_depth_strap_pin, bus_select_straps}));
  task automatic chk(string w, logic [7:0] e, logic [7:0] s);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", w, e, s);
    end
  endtask
  task automatic cyc(int n); repeat (n) @(posedge clk); endtask
  task automatic cap(logic [3:0] s);
    @(posedge clk); pg_q <= 0; st_q <= s; cyc(10);
    pg_q <= 1; cyc(12); st_q <= ~s; cyc(8); #1;
  endtask
  task automatic t_straps;
    for (int i = 0; i < 16; i++) begin
      cap(i[3:0]);
      chk("sel", i[3], graphics_port_select);
      chk("dvo", !i[3], digital_video_out_mode);
      chk("qd", i[2] ? 8'h0c : 8'h01, inorder_queue_depth);
      chk("frq", i[1:0], bus_frequency_select);
      chk("rsv", i[1:0] == 2'h3, freq_reserved);
      chk("wrd", i[3:0], strap_word);
      chk("qdb", i[2], inorder_queue_depth_bit);
    end
  endtask
  task automatic t_route;
    cap(4'h0);
    @(posedge clk); cap_wr <= 1; cap_wdata <= 8'h5a; cfg_to_port <= 1;
    @(posedge clk); cap_wr <= 0; cyc(2); #1;
    chk("hub", 1, cfg_pass_hub_link);
    chk("en", 0, graphics_port_enable);
    chk("ptr", 0, cap_next_ptr);
    @(posedge clk); port_v3_detect_bit <= 1; cyc(2); #1;
    chk("v3", 1, graphics_port_select);
    chk("wrd", 8'h08, strap_word);
    chk("clm", 1, cfg_claim_port);
    chk("hub", 0, cfg_pass_hub_link);
    chk("ptr", 0, cap_next_ptr);
    @(posedge clk); cap_wr <= 1; cap_wdata <= 8'hc3;
    @(posedge clk); cap_wr <= 0; cyc(2); #1;
    chk("ptr", 8'hc3, cap_next_ptr);
    @(posedge clk); port_v3_detect_bit <= 0; cyc(3); #1;
    chk("v3", 0, graphics_port_select);
    chk("ptr", 0, cap_next_ptr);
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    cyc(10); rst <= 0; cyc(1); #1;
    chk("rq", 1, inorder_queue_depth);
    t_straps; t_route; give_verdict;
  end
  initial begin
    #20000; n_fail++; give_verdict;
  end
endmodule
`default_nettype wire
